// *** bus_attr_map.svh ***
// Register offsets, field positions, reset values and bus encodings.
`ifndef BUS_ATTR_MAP_SVH
`define BUS_ATTR_MAP_SVH

// Register byte offsets on the control bus.
`define OFF_CONFIG        8'h00
`define OFF_EXT_ACCESS    8'h04
`define OFF_MASTER_ADDR   8'h08
`define OFF_MASTER_CMD    8'h0C
`define OFF_STATUS        8'h10

// Reset values.
`define RST_CONFIG        1'h0
`define RST_EXT_ACCESS    4'h0
`define RST_WORD          32'h0000_0000

// Field positions in the configuration and command registers.
`define CFG_BCAST_BIT     0
`define CMD_TYPE_LSB      0
`define CMD_SIZE_LSB      8
`define CMD_BURST_BIT     12
`define CMD_INHIBIT_BIT   13

// Field positions in the status register.
`define ST_BUSY_BIT       0
`define ST_DROPPED_BIT    1
`define ST_REFUSED_BIT    2
`define ST_ACTION_LSB     4
`define ST_SNOOP_BURST    12

// Transfer type codes, first wire of the bus in the top bit.
`define TT_CLEAN          5'h00
`define TT_FLUSH          5'h04
`define TT_SYNC           5'h08
`define TT_KILL           5'h0C
`define TT_BARRIER        5'h10
`define TT_ECTL_WRITE     5'h14
`define TT_TLB_INV        5'h18
`define TT_ECTL_READ      5'h1C
`define TT_RESV_SET       5'h01
`define TT_TLB_SYNC       5'h09
`define TT_ICBI           5'h0D
`define TT_WR_FLUSH       5'h02
`define TT_WR_KILL        5'h06
`define TT_READ           5'h0A
`define TT_RWITM          5'h0E
`define TT_WR_FLUSH_AT    5'h12
`define TT_READ_AT        5'h1A
`define TT_RWITM_AT       5'h1E
`define TT_READ_NOCACHE   5'h0B

// Transfer size codes.
`define TSIZE_8B          3'h0
`define TSIZE_BURST       3'h2
`define TSIZE_MAX_LEGAL   3'h4

// Bus response codes.
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// *** bus_attr_pkg.sv ***
// Types shared by the bus attribute and snoop logic.
package bus_attr_pkg;

  // Master address tenure state.
  typedef enum logic [1:0] {
    TEN_IDLE  = 2'b01,
    TEN_DRIVE = 2'b10
  } tenure_state_type;

  // Action taken on a snoop hit.
  typedef enum logic [4:0] {
    ACT_NONE         = 5'b00001,
    ACT_CLEAN        = 5'b00010,
    ACT_FLUSH        = 5'b00100,
    ACT_FLUSH_CANCEL = 5'b01000,
    ACT_KILL_CANCEL  = 5'b10000
  } snoop_action_type;

endpackage : bus_attr_pkg

// *** bus_far_side_model.sv ***
// Far side model: address acknowledge and cache tag lookup answers.
`timescale 1ns/10ps

module bus_far_side_model (
  // Clock and reset.
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Tenure enable and lookup request from the block.
  input  wire logic       attr_oe,
  input  wire logic       snoop_lookup,
  // Bench controls: hit answer and acknowledge delay.
  input  wire logic       hit_want,
  input  wire logic [3:0] ack_delay,
  // Answers to the block.
  output logic            address_ack_in,
  output logic            snoop_hit
);
  logic [3:0] wait_r;  // Cycles waited in this tenure.
  logic       acked_r; // Tenure already acknowledged.

  // One acknowledge per tenure after a delay, negated a cycle later.
  always_ff @(posedge aclk) begin
    if (!aresetn || !attr_oe) begin
      wait_r         <= 4'h0;
      acked_r        <= 1'b0;
      address_ack_in <= 1'b0;
    end else begin
      address_ack_in <= !acked_r && wait_r == ack_delay;
      acked_r        <= acked_r | (wait_r == ack_delay);
      wait_r         <= wait_r + 4'h1;
    end
  end

  // Hit is valid only after a lookup; otherwise it keeps changing.
  always_ff @(posedge aclk) begin
    if (!aresetn)
      snoop_hit <= 1'b0;
    else
      snoop_hit <= snoop_lookup ? hit_want : !snoop_hit;
  end
endmodule : bus_far_side_model

// *** bus_transfer_attribute_snoop.sv ***
// Bus master transfer attributes and snoop response with a control slave.
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "bus_attr_map.svh"

module bus_transfer_attribute_snoop (
  // Clock and synchronous active-low reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Control bus write address and data.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // Control bus write response.
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // Control bus read.
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Master address tenure pins.
  output logic [31:0]      address_out,
  output logic [4:0]       transfer_type_out,
  output logic [2:0]       transfer_size,
  output logic             burst_indicator_out,
  output logic             cache_inhibit_out,
  output logic             attr_oe,
  input  wire logic        address_ack_in,
  // Snooped pins from other masters.
  input  wire logic        snoop_start_in,
  input  wire logic [4:0]  transfer_type_in,
  input  wire logic        burst_indicator_in,
  input  wire logic        global_snoop_request,
  // Data cache lookup and actions.
  output logic             snoop_lookup,
  input  wire logic        snoop_hit,
  output logic             clean_block,
  output logic             flush_block,
  output logic             kill_block,
  output logic             cancel_reservation
);

  ////////////////////////////////////////////////////////////////////////////
  // Software state.
  logic        bcast_en_r;   // Address broadcast enable.
  logic [3:0]  ext_access_r; // Resource id, top bit goes to burst line.
  logic [31:0] maddr_r;      // Address for the next master tenure.
  logic [31:0] mcmd_r;       // Last command written.
  logic        dropped_r;    // Sticky: address-only tenure suppressed.
  logic        refused_r;    // Sticky: illegal size or busy.

  // Bus handshake state.
  logic        aw_got_r;     // Write address held.
  logic        w_got_r;      // Write data held.
  logic [7:0]  awaddr_r;     // Held write address.
  logic [31:0] wdata_r;      // Held write data.
  logic [3:0]  wstrb_r;      // Held byte enables.

  // Tenure and snoop state.
  bus_attr_pkg::tenure_state_type ten_r;
  bus_attr_pkg::snoop_action_type action;
  bus_attr_pkg::snoop_action_type last_act_r;
  logic [4:0]  snp_type_r;   // Latched snooped type.
  logic        snp_burst_r;  // Burst indicator sampled at snoop.
  logic        snp_pend_r;   // Lookup issued, hit due now.
  logic [4:0]  snp_type_p_r; // Type of the lookup whose hit is due now.

  // Two-stage synchronisers for pins.
  logic [8:0]  pin_s1_r;
  logic [8:0]  pin_s2_r;
  logic        ack_s;
  logic        start_s;
  logic [4:0]  type_s;
  logic        burst_s;
  logic        gbl_s;

  // Decoded bus events.
  logic        wr_fire;
  logic        cmd_fire;
  logic [4:0]  cmd_type;
  logic [2:0]  cmd_size;
  logic        cmd_burst;
  logic        cmd_ext;
  logic        cmd_aonly;
  logic        cmd_bad_size;

  // Tells whether a type is an address-only command placed by a master.
  function automatic logic is_addr_only(input logic [4:0] t);
    is_addr_only = (t == `TT_CLEAN) || (t == `TT_FLUSH) ||
                   (t == `TT_SYNC)  || (t == `TT_KILL)  ||
                   (t == `TT_BARRIER);
  endfunction : is_addr_only

  // Merges a write into a word under its byte enables.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        merge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only the second stage is read.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_r <= 9'h000;
      pin_s2_r <= 9'h000;
    end else begin
      pin_s1_r <= {address_ack_in, snoop_start_in, transfer_type_in,
                   burst_indicator_in, global_snoop_request};
      pin_s2_r <= pin_s1_r;
    end
  end

  assign ack_s   = pin_s2_r[8];
  assign start_s = pin_s2_r[7];
  assign type_s  = pin_s2_r[6:2];
  assign burst_s = pin_s2_r[1];
  assign gbl_s   = pin_s2_r[0];

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data taken in either order.
  assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= `RST_WORD;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end else begin
      // Ready is offered only while the channel holds nothing.
      s_axi_awready <= !aw_got_r && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_got_r && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        // Response follows both halves; only an unmapped offset is an error.
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_r == `OFF_CONFIG ||
                         awaddr_r == `OFF_EXT_ACCESS ||
                         awaddr_r == `OFF_MASTER_ADDR ||
                         awaddr_r == `OFF_MASTER_CMD ||
                         awaddr_r == `OFF_STATUS) ? `RESP_OKAY
                                                  : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes.
  assign cmd_fire = wr_fire && (awaddr_r == `OFF_MASTER_CMD);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bcast_en_r   <= `RST_CONFIG;
      ext_access_r <= `RST_EXT_ACCESS;
      maddr_r      <= `RST_WORD;
      mcmd_r       <= `RST_WORD;
    end else if (wr_fire) begin
      if (awaddr_r == `OFF_CONFIG && wstrb_r[0]) begin
        bcast_en_r <= wdata_r[`CFG_BCAST_BIT];
      end
      if (awaddr_r == `OFF_EXT_ACCESS && wstrb_r[0]) begin
        ext_access_r <= wdata_r[3:0];
      end
      if (awaddr_r == `OFF_MASTER_ADDR) begin
        maddr_r <= merge(maddr_r, wdata_r, wstrb_r);
      end
      if (cmd_fire) begin
        mcmd_r <= merge(mcmd_r, wdata_r, wstrb_r);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: one cycle from address to data.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= `RST_WORD;
      s_axi_rresp   <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `RESP_OKAY;
      s_axi_rdata   <= `RST_WORD;
      unique case (s_axi_araddr)
        `OFF_CONFIG:      s_axi_rdata[`CFG_BCAST_BIT] <= bcast_en_r;
        `OFF_EXT_ACCESS:  s_axi_rdata[3:0] <= ext_access_r;
        `OFF_MASTER_ADDR: s_axi_rdata <= maddr_r;
        `OFF_MASTER_CMD:  s_axi_rdata <= mcmd_r;
        `OFF_STATUS: begin
          s_axi_rdata[`ST_BUSY_BIT]    <= ten_r == bus_attr_pkg::TEN_DRIVE;
          s_axi_rdata[`ST_DROPPED_BIT] <= dropped_r;
          s_axi_rdata[`ST_REFUSED_BIT] <= refused_r;
          s_axi_rdata[`ST_ACTION_LSB +: 5] <= last_act_r;
          s_axi_rdata[`ST_SNOOP_BURST] <= snp_burst_r;
        end
        default: s_axi_rresp <= `RESP_SLVERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else begin
      s_axi_arready <= !s_axi_rvalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode from the incoming write word.
  assign cmd_type     = wdata_r[`CMD_TYPE_LSB +: 5];
  assign cmd_size     = wdata_r[`CMD_SIZE_LSB +: 3];
  assign cmd_burst    = wdata_r[`CMD_BURST_BIT];
  assign cmd_ext      = (cmd_type == `TT_ECTL_WRITE) ||
                        (cmd_type == `TT_ECTL_READ);
  assign cmd_aonly    = is_addr_only(cmd_type);
  assign cmd_bad_size = !cmd_burst && !cmd_ext &&
                        (cmd_size > `TSIZE_MAX_LEGAL);

  // Master tenure: attributes follow the address pins exactly.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ten_r               <= bus_attr_pkg::TEN_IDLE;
      address_out         <= `RST_WORD;
      transfer_type_out   <= 5'h00;
      transfer_size       <= `TSIZE_8B;
      burst_indicator_out <= 1'b0;
      cache_inhibit_out   <= 1'b0;
      attr_oe             <= 1'b0;
    end else begin
      unique case (ten_r)
        bus_attr_pkg::TEN_IDLE: begin
          if (cmd_fire && !(cmd_aonly && !bcast_en_r) && !cmd_bad_size) begin
            ten_r             <= bus_attr_pkg::TEN_DRIVE;
            attr_oe           <= 1'b1;
            address_out       <= maddr_r;
            transfer_type_out <= cmd_type;
            if (cmd_ext) begin
              transfer_size       <= ext_access_r[2:0];
              burst_indicator_out <= ext_access_r[3];
              cache_inhibit_out   <= 1'b0;
            end else if (cmd_burst) begin
              transfer_size       <= `TSIZE_BURST;
              burst_indicator_out <= 1'b1;
              cache_inhibit_out   <= 1'b0;
            end else begin
              transfer_size       <= cmd_size;
              burst_indicator_out <= 1'b0;
              cache_inhibit_out   <= wdata_r[`CMD_INHIBIT_BIT];
            end
          end
        end
        bus_attr_pkg::TEN_DRIVE: begin
          if (ack_s) begin
            ten_r   <= bus_attr_pkg::TEN_IDLE;
            attr_oe <= 1'b0;
          end
        end
      endcase
    end
  end

  // Sticky error flags; a new event wins over a write-one clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dropped_r <= 1'b0;
      refused_r <= 1'b0;
    end else begin
      if (cmd_fire && cmd_aonly && !bcast_en_r) begin
        dropped_r <= 1'b1;
      end else if (wr_fire && awaddr_r == `OFF_STATUS &&
                   wdata_r[`ST_DROPPED_BIT]) begin
        dropped_r <= 1'b0;
      end
      if (cmd_fire && (cmd_bad_size || ten_r == bus_attr_pkg::TEN_DRIVE)) begin
        refused_r <= 1'b1;
      end else if (wr_fire && awaddr_r == `OFF_STATUS &&
                   wdata_r[`ST_REFUSED_BIT]) begin
        refused_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Snoop: lookup on a global start, act on the hit a cycle later.
  // The decode follows the hit stage, so back-to-back starts keep their type.
  snoop_decoder u_decoder (
    .transfer_type (snp_type_p_r),
    .action        (action)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      snoop_lookup       <= 1'b0;
      snp_pend_r         <= 1'b0;
      snp_type_r         <= 5'h00;
      snp_type_p_r       <= 5'h00;
      snp_burst_r        <= 1'b0;
      last_act_r         <= bus_attr_pkg::ACT_NONE;
      clean_block        <= 1'b0;
      flush_block        <= 1'b0;
      kill_block         <= 1'b0;
      cancel_reservation <= 1'b0;
    end else begin
      snoop_lookup <= start_s && gbl_s;
      snp_pend_r   <= snoop_lookup;
      // A later start may reload the latch while this hit is still due.
      snp_type_p_r <= snp_type_r;
      if (start_s && gbl_s) begin
        snp_type_r  <= type_s;
        snp_burst_r <= burst_s;
      end
      clean_block        <= snp_pend_r && snoop_hit &&
                            action == bus_attr_pkg::ACT_CLEAN;
      flush_block        <= snp_pend_r && snoop_hit &&
                            (action == bus_attr_pkg::ACT_FLUSH ||
                             action == bus_attr_pkg::ACT_FLUSH_CANCEL);
      kill_block         <= snp_pend_r && snoop_hit &&
                            action == bus_attr_pkg::ACT_KILL_CANCEL;
      cancel_reservation <= snp_pend_r && snoop_hit &&
                            (action == bus_attr_pkg::ACT_FLUSH_CANCEL ||
                             action == bus_attr_pkg::ACT_KILL_CANCEL);
      if (snp_pend_r && snoop_hit) begin
        last_act_r <= action;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence hit_of(logic [4:0] t);
    snp_pend_r && snoop_hit && snp_type_p_r == t;
  endsequence

  kill_flush_cancel_a: assert property (
    hit_of(`TT_KILL) |=> flush_block && cancel_reservation && !kill_block)
    else $error("kill hit did not flush and cancel");
  write_kill_a: assert property (
    hit_of(`TT_WR_KILL) |=> kill_block && cancel_reservation && !flush_block)
    else $error("write with kill hit did not kill and cancel");
  read_clean_a: assert property (
    hit_of(`TT_READ) |=> clean_block && !cancel_reservation)
    else $error("read hit did not clean");
  rwitm_flush_a: assert property (
    hit_of(`TT_RWITM_AT) |=> flush_block && !cancel_reservation)
    else $error("intent to modify hit did not flush");
  nocache_clean_a: assert property (
    hit_of(`TT_READ_NOCACHE) |=> clean_block && !flush_block && !kill_block)
    else $error("no-cache read hit did more than clean");
  aonly_quiet_a: assert property (
    hit_of(`TT_SYNC) |=> !clean_block && !flush_block && !cancel_reservation)
    else $error("address-only hit caused an action");
  bcast_gate_a: assert property (
    $rose(attr_oe) |-> !is_addr_only(transfer_type_out) || bcast_en_r)
    else $error("address-only tenure without broadcast enable");
  burst_size_a: assert property (
    attr_oe && burst_indicator_out && transfer_type_out != `TT_ECTL_READ &&
    transfer_type_out != `TT_ECTL_WRITE
    |-> transfer_size == `TSIZE_BURST && !cache_inhibit_out)
    else $error("burst without 32-byte code or with inhibit");
  legal_size_a: assert property (
    attr_oe && !burst_indicator_out |-> transfer_size <= `TSIZE_MAX_LEGAL ||
    transfer_type_out == `TT_ECTL_READ || transfer_type_out == `TT_ECTL_WRITE)
    else $error("five to seven byte size driven");
  attr_hold_a: assert property (
    attr_oe && !ack_s |=> attr_oe && $stable(address_out) &&
    $stable(transfer_size) && $stable(cache_inhibit_out))
    else $error("attributes changed during tenure");
  global_only_a: assert property (
    start_s && !gbl_s |=> !snoop_lookup)
    else $error("non-global transfer was snooped");

endmodule : bus_transfer_attribute_snoop

// *** bus_transfer_attribute_snoop_tb_top.sv ***
// Self-checking bench for the bus attribute and snoop block.
`timescale 1ns/10ps
`include "bus_attr_map.svh"

module bus_transfer_attribute_snoop_tb_top;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, address_out;
  logic [3:0] s_axi_wstrb = 4'hF, ack_delay = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, hit_want = 1'b0;
  logic snoop_start_in = 1'b0, burst_indicator_in = 1'b0;
  logic global_snoop_request = 1'b0;
  logic [4:0] transfer_type_in = 5'h00, transfer_type_out;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, burst_indicator_out, cache_inhibit_out, attr_oe;
  logic address_ack_in, snoop_lookup, snoop_hit, clean_block;
  logic flush_block, kill_block, cancel_reservation;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] transfer_size;
  logic [31:0] rnd = 32'h0000_0036;
  logic [4:0] mty [14] = '{5'h00, 5'h02, 5'h04, 5'h08, 5'h0C, 5'h10,
    5'h14, 5'h1C, 5'h0A, 5'h0E, 5'h12, 5'h06, 5'h1A, 5'h1E};
  int n_errors = 0, n_compared = 0;

  // Clock, inverted every half period.
  always #5 aclk = ~aclk;

  bus_transfer_attribute_snoop bus_transfer_attribute_snoop_inst (.*);
  bus_far_side_model bus_far_side_model_inst (.*);

  ////////////////////////////////////////////////////////////////////////
  // Random source and expectations.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
  endfunction : lfsr

  // Hit action as {clean, flush, kill, cancel}.
  function automatic logic [3:0] snp(input logic [4:0] t);
    case (t)
      5'h0C, 5'h02, 5'h12: return 4'h5;
      5'h06: return 4'h3;
      5'h0A, 5'h1A, 5'h0B: return 4'h8;
      5'h0E, 5'h1E: return 4'h4;
      default: return 4'h0;
    endcase
  endfunction : snp

  // Tenure as {enable, type, size, burst, inhibit}.
  function automatic logic [10:0] ten(input logic [13:0] c,
                                      input logic g, input logic [3:0] e);
    if (c[4:0] == 5'h14 || c[4:0] == 5'h1C)
      return {1'b1, c[4:0], e[2:0], e[3], 1'b0};
    if (c[1:0] == 2'h0 && c[4:0] <= 5'h10 && !g)
      return 11'h000;
    if (c[12])
      return {1'b1, c[4:0], `TSIZE_BURST, 2'h2};
    if (c[10:8] > `TSIZE_MAX_LEGAL)
      return 11'h000;
    return {1'b1, c[4:0], c[10:8], 1'b0, c[13]};
  endfunction : ten

  ////////////////////////////////////////////////////////////////////////
  // Compare, bus cycles and verdict.
  task automatic ck(input logic [31:0] got, exp, input string m);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : ck

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : rd

  task automatic give_verdict();
    $display("errors %0d, comparisons %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict

  // Watchdog, far beyond the expected few thousand cycles.
  initial begin
    #300000;
    n_errors++;
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence: register bus, master tenures, then snooping.
  initial begin
    logic [31:0] v;
    logic [1:0] r;
    logic [13:0] c;
    logic [10:0] e;
    logic [4:0] t;
    logic [3:0] got, lk;
    logic g, h, a;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`OFF_CONFIG, v, r);
    ck(v, `RST_WORD, "config reset");
    rd(8'h40, v, r);
    ck(r, `RESP_SLVERR, "unmapped read response");
    ck(v, 32'h0000_0000, "unmapped read data");
    wr(8'h44, 32'hFFFF_FFFF, r);
    ck(r, `RESP_SLVERR, "unmapped write");
    for (int i = 0; i < 42; i++) begin
      rnd = lfsr(rnd);
      g = (i == 0) ? 1'b0 : rnd[15];
      c = {rnd[13:12], 1'b0, rnd[10:8], 3'h0, mty[i % 14]};
      if (i == 1) c[12:8] = 5'h07;
      if (c[1:0] == 2'h0 && c[4:0] <= 5'h10) c[12:10] = 3'h0;
      e = ten(c, g, rnd[19:16]);
      // Address-only command without broadcast enable is dropped.
      a = c[1:0] == 2'h0 && c[4:0] <= 5'h10 && !g;
      ack_delay <= {1'b0, rnd[22:20]};
      wr(`OFF_CONFIG, {31'h0, g}, r);
      wr(`OFF_EXT_ACCESS, {28'h0, rnd[19:16]}, r);
      wr(`OFF_MASTER_ADDR, rnd, r);
      wr(`OFF_MASTER_CMD, {18'h0, c}, r);
      #1;
      ck(attr_oe, e[10], "tenure issue");
      while (attr_oe === 1'b1) begin
        ck({attr_oe, transfer_type_out, transfer_size, burst_indicator_out,
            cache_inhibit_out}, e, "attrs");
        ck(address_out, rnd, "address");
        @(posedge aclk);
        #1;
      end
      // Sticky flags tell a dropped from a refused command, then clear.
      rd(`OFF_STATUS, v, r);
      ck(v[2:0], {!e[10] && !a, a, 1'b0}, "status flags");
      wr(`OFF_STATUS, 32'h0000_0006, r);
    end
    for (int i = 0; i < 80; i++) begin
      rnd = lfsr(rnd);
      t = (i < 32) ? i[4:0] : rnd[4:0];
      g = (i < 32) | rnd[5];
      h = (i < 32) | rnd[6];
      transfer_type_in <= t;
      global_snoop_request <= g;
      hit_want <= h;
      burst_indicator_in <= rnd[7];
      snoop_start_in <= 1'b1;
      @(posedge aclk);
      snoop_start_in <= 1'b0;
      transfer_type_in <= ~t;
      got = 4'h0;
      lk = 4'h0;
      repeat (8) begin
        @(posedge aclk);
        #1;
        got |= {clean_block, flush_block, kill_block, cancel_reservation};
        lk += {3'h0, snoop_lookup};
      end
      ck(lk, g, "lookup");
      ck(got, snp(t) & {4{g & h}}, "action");
      if (t == `TT_READ_NOCACHE && g) begin
        rd(`OFF_STATUS, v, r);
        ck(v[`ST_SNOOP_BURST], rnd[7], "snoop burst");
        if (h) ck(v[8:4], 5'h02, "last action");
      end
    end
    give_verdict();
  end
endmodule : bus_transfer_attribute_snoop_tb_top

// *** snoop_decoder.sv ***
// Maps a snooped transfer type to the cache action taken on a hit.
`timescale 1ns/10ps
`include "bus_attr_map.svh"

module snoop_decoder (
  // Snooped transfer type.
  input  wire logic [4:0]                  transfer_type,
  // Chosen action for a hit.
  output bus_attr_pkg::snoop_action_type   action
);

  // Pure decode; the caller qualifies it with the hit and global term.
  always_comb begin
    unique casez (transfer_type)
      `TT_KILL:         action = bus_attr_pkg::ACT_FLUSH_CANCEL;
      `TT_WR_FLUSH,
      `TT_WR_FLUSH_AT:  action = bus_attr_pkg::ACT_FLUSH_CANCEL;
      `TT_WR_KILL:      action = bus_attr_pkg::ACT_KILL_CANCEL;
      `TT_READ,
      `TT_READ_AT:      action = bus_attr_pkg::ACT_CLEAN;
      `TT_RWITM,
      `TT_RWITM_AT:     action = bus_attr_pkg::ACT_FLUSH;
      `TT_READ_NOCACHE: action = bus_attr_pkg::ACT_CLEAN;
      `TT_CLEAN, `TT_FLUSH, `TT_SYNC, `TT_BARRIER, `TT_TLB_INV,
      `TT_TLB_SYNC, `TT_ICBI, `TT_RESV_SET,
      `TT_ECTL_WRITE, `TT_ECTL_READ:
                        action = bus_attr_pkg::ACT_NONE;
      default:          action = bus_attr_pkg::ACT_NONE;
    endcase
  end

endmodule : snoop_decoder
